// File: logic/acc_pkg.sv
// acquisition chain control: shared constants and carrier types
// assumes one 20 MHz clock and a word-aligned Avalon-MM register window
package acc_pkg;
	// register byte offsets (one word per 8-bit register)
	localparam logic [4:0] ACC_OFF_RES_LO = 5'h00;
	localparam logic [4:0] ACC_OFF_RES_HI = 5'h04;
	localparam logic [4:0] ACC_OFF_CFG0 = 5'h08;
	localparam logic [4:0] ACC_OFF_CFG1 = 5'h0C;
	localparam logic [4:0] ACC_OFF_CFG2 = 5'h10;
	localparam logic [4:0] ACC_OFF_CFG3 = 5'h14;
	localparam logic [4:0] ACC_OFF_CFG4 = 5'h18;
	localparam logic [4:0] ACC_OFF_CFG5 = 5'h1C;
	// field positions
	localparam int ACC_B_START = 7;
	localparam int ACC_B_DEF = 6;
	localparam int ACC_B_BUSY = 7;
	// reset values
	localparam logic [7:0] ACC_RST_CFG0 = 8'h28;
	localparam logic [7:0] ACC_RST_CFG1 = 8'hF0;
	localparam logic [7:0] ACC_RST_CFG2 = 8'h00;
	localparam logic [7:0] ACC_RST_CFG3 = 8'h00;
	localparam logic [7:0] ACC_RST_CFG4 = 8'h00;
	localparam logic [7:0] ACC_RST_CFG5 = 8'h00;
	// restore-settings values: stages off, modulator on, fastest rate
	localparam logic [1:0] ACC_DEF_NELC = 2'h1;
	localparam logic [2:0] ACC_DEF_OSR = 3'h2;
	localparam logic [1:0] ACC_DEF_MBIAS = 2'h3;
	localparam logic [3:0] ACC_DEF_ENABLE = 4'h1;
	localparam logic [1:0] ACC_DEF_RATE = 2'h0;
	// sampling clock: rc oscillator and 8 kHz rate at 20 MHz clock
	localparam int ACC_CLK_HZ = 20000000;
	localparam int ACC_RC_HZ = 2000000;
	localparam int ACC_FIX_HZ = 8000;
	localparam logic [15:0] ACC_RC_DIV = 16'(ACC_CLK_HZ / ACC_RC_HZ);
	localparam logic [15:0] ACC_FIX_DIV = 16'(ACC_CLK_HZ / ACC_FIX_HZ);

	// configuration carried to the analog side
	typedef struct packed {
		logic [4:0] input_channel_select;
		logic ref_pair_select;
		logic [3:0] block_enable;
		logic [1:0] modulator_bias_select;
		logic [1:0] amplifier_bias_select;
		logic [1:0] sample_rate_select;
		logic stage1_gain_select;
		logic [1:0] stage2_gain_select;
		logic [3:0] stage2_shift_select;
		logic [6:0] stage3_gain_select;
		logic [6:0] stage3_shift_select;
	} acc_analog_t;

	typedef enum logic [1:0] {ACC_IDLE, ACC_RUN} acc_state_t;
endpackage : acc_pkg

// File: logic/acc_ctrl.sv
// acquisition chain control: registers, conversion sequencer, sample clock
// assumes an Avalon-MM master on clk_in and a modulator giving a +/-1 bit
// per sampling tick; synchronous active-high reset
//
// Functional notes
// [R1] trigger bit starts one conversion after current one; reads zero
// [R2] two to chop count elementary conversions, polarity flips between them
// [R3] each elementary conversion takes two to three plus exponent samples
// [R4] repeat bit starts conversion and restarts after each while set
// [R5] test bit stays zero and ignores writes
// [R6] modulator bias field drives bias of 25 to 100 percent
// [R7] amplifier bias field sets bias of all gain stages
// [R8] enable bit 0 modulator, bits 1-3 stages; disabled stage bypassed
// [R9] rate field picks rc/4, rc/8, rc/32 or fixed 8 kHz
// [R10] stage one gain 1 or 10; stage two gain 1,2,5,10
// [R11] stage three gain is seven-bit field times one twelfth
// [R12] stage two shift sign-magnitude, 0.2 steps, limited to plus/minus one
// [R13] stage three shift sign-magnitude, 1/12 steps, up to 5.25
// [R14] busy flag set at actual conversion start, cleared at end
// [R15] busy may lag a start write by one sampling period
// [R16] restore bit reloads defaults and restarts conversion at once
// [R17] input select: mode bit, swap bit, three channel bits
// [R18] reference bit selects pair one-zero or three-two
// [R19] result registers written and done pulse at each conversion end
// [R20] single-shot uses same sequence, only waiting for trigger
// [R21] result is 16-bit two's complement in low and high bytes
// [R22] both result bytes update together from one conversion
`default_nettype none
module acc_ctrl
	import acc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// avalon-mm slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// modulator bit stream, one bit per sampling tick
	input wire logic mod_bit_in,
	// analog controls
	output acc_analog_t analog_out,
	output logic chop_invert_out,
	output logic sample_tick_out,
	output logic conv_done_out
);
	logic [7:0] cfg0_reg, cfg1_reg, cfg2_reg, cfg3_reg, cfg4_reg, cfg5_reg;
	logic [15:0] result_reg;
	logic ack_reg;
	logic busy_reg;
	logic pend_reg;
	logic chop_reg;
	logic done_reg;
	logic tick_reg;
	logic [15:0] div_reg;
	logic [9:0] osr_cnt_reg;
	logic [2:0] elem_cnt_reg;
	logic [15:0] acc_reg;
	acc_state_t state_reg;
	logic wr_acc, rd_acc, def_wr, start_wr, repeat_conversion_rise, last_sample, last_elem;
	logic repeat_conversion_prev_reg;
	logic [15:0] div_lim;
	logic [15:0] acc_next;

	// power of two helper used for both counts
	function automatic logic [10:0] pow2(input logic [3:0] e);
		pow2 = 11'h001 << e;
	endfunction

	// one-cycle ack: request held by master until waitrequest is low;
	// ack_reg mirrors the low phase of waitrequest, so a read is looked up on
	// the edge that lowers waitrequest and its data stands when sampled, and a
	// write lands only on the edge at which the master sees waitrequest low
	assign wr_acc = avs_write_in && ack_reg;
	assign rd_acc = avs_read_in && !ack_reg;
	assign def_wr = wr_acc && avs_address_in == ACC_OFF_CFG5 && avs_writedata_in[ACC_B_DEF];
	assign start_wr = wr_acc && avs_address_in == ACC_OFF_CFG0 && avs_writedata_in[ACC_B_START];

	// bus handshake
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
		end
	end

	// read mux straight into the output register, one cycle ahead of the
	// master's sampling edge; trigger and restore bits read zero, unmapped zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (rd_acc) begin
			case (avs_address_in)
				ACC_OFF_RES_LO: avs_readdata_out <= {24'h000000, result_reg[7:0]}; // [R21]
				ACC_OFF_RES_HI: avs_readdata_out <= {24'h000000, result_reg[15:8]}; // [R21]
				ACC_OFF_CFG0: avs_readdata_out <= {24'h000000, 1'b0, cfg0_reg[6:0]}; // [R1]
				ACC_OFF_CFG1: avs_readdata_out <= {24'h000000, cfg1_reg};
				ACC_OFF_CFG2: avs_readdata_out <= {24'h000000, cfg2_reg};
				ACC_OFF_CFG3: avs_readdata_out <= {24'h000000, cfg3_reg};
				ACC_OFF_CFG4: avs_readdata_out <= {24'h000000, cfg4_reg};
				ACC_OFF_CFG5: avs_readdata_out <=
					{24'h000000, busy_reg, 1'b0, cfg5_reg[5:0]}; // [R14]
				default: avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// configuration registers; restore command overrides the same write
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg0_reg <= ACC_RST_CFG0;
			cfg1_reg <= ACC_RST_CFG1;
			cfg2_reg <= ACC_RST_CFG2;
			cfg3_reg <= ACC_RST_CFG3;
			cfg4_reg <= ACC_RST_CFG4;
			cfg5_reg <= ACC_RST_CFG5;
		end else if (def_wr) begin
			// restore: reload cfg0, modulator bias, enables and rate; keep amplifier bias, stage two and three settings, input and reference
			cfg0_reg <= {1'b0, ACC_DEF_NELC, ACC_DEF_OSR, 2'b00}; // [R16]
			cfg1_reg <= {ACC_DEF_MBIAS, cfg1_reg[5:4], ACC_DEF_ENABLE}; // [R16]
			cfg2_reg <= {ACC_DEF_RATE, cfg2_reg[5:0]}; // [R16]
		end else if (wr_acc) begin
			case (avs_address_in)
				// start bit not stored, test bit forced low
				ACC_OFF_CFG0: cfg0_reg <= {1'b0, avs_writedata_in[6:1], 1'b0}; // [R5]
				ACC_OFF_CFG1: cfg1_reg <= avs_writedata_in[7:0];
				ACC_OFF_CFG2: cfg2_reg <= avs_writedata_in[7:0];
				ACC_OFF_CFG3: cfg3_reg <= avs_writedata_in[7:0];
				ACC_OFF_CFG4: cfg4_reg <= {1'b0, avs_writedata_in[6:0]};
				ACC_OFF_CFG5: cfg5_reg <= {2'b00, avs_writedata_in[5:0]};
				default: ;
			endcase
		end
	end

	// sampling clock divider; 8 kHz code uses its own divide
	always_comb begin
		case (cfg2_reg[7:6]) // [R9]
			2'b00: div_lim = 16'(ACC_RC_DIV * 16'd4);
			2'b01: div_lim = 16'(ACC_RC_DIV * 16'd8);
			2'b10: div_lim = 16'(ACC_RC_DIV * 16'd32);
			default: div_lim = ACC_FIX_DIV;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || def_wr) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (div_reg >= div_lim - 16'h0001) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b1; // [R9]
		end else begin
			div_reg <= div_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	assign last_sample = osr_cnt_reg == 10'(pow2({1'b0, cfg0_reg[4:2]} + 4'h3) - 11'h001);
	assign last_elem = elem_cnt_reg == 3'(pow2({2'b00, cfg0_reg[6:5]}) - 11'h001);
	assign acc_next = mod_bit_in ^ chop_reg ? acc_reg + 16'h0001 : acc_reg - 16'h0001;
	assign repeat_conversion_rise = wr_acc && avs_address_in == ACC_OFF_CFG0 && avs_writedata_in[1]
		&& !cfg0_reg[1];

	// pending single-shot request, deferred while busy
	always_ff @(posedge clk_in) begin
		if (rst_in || def_wr) begin
			pend_reg <= 1'b0;
		end else if (start_wr || repeat_conversion_rise) begin
			pend_reg <= 1'b1; // [R1] [R4]
		end else if (state_reg == ACC_IDLE && tick_reg) begin
			pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			repeat_conversion_prev_reg <= 1'b0;
		end else begin
			repeat_conversion_prev_reg <= cfg0_reg[1];
		end
	end

	// conversion sequencer; starts on a sampling tick, or at once on restore
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= ACC_IDLE;
			busy_reg <= 1'b0;
			osr_cnt_reg <= 10'h000;
			elem_cnt_reg <= 3'h0;
			chop_reg <= 1'b0;
			acc_reg <= 16'h0000;
			result_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else if (def_wr) begin
			// abandon running conversion and restart at once
			state_reg <= ACC_RUN; // [R16]
			busy_reg <= 1'b1;
			osr_cnt_reg <= 10'h000;
			elem_cnt_reg <= 3'h0;
			chop_reg <= 1'b0;
			acc_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ACC_IDLE: begin
					if (tick_reg && (pend_reg || cfg0_reg[1])) begin
						state_reg <= ACC_RUN; // [R14] [R15] [R20]
						busy_reg <= 1'b1;
						osr_cnt_reg <= 10'h000;
						elem_cnt_reg <= 3'h0;
						chop_reg <= 1'b0;
						acc_reg <= 16'h0000;
					end
				end
				ACC_RUN: begin
					if (tick_reg) begin
						acc_reg <= acc_next;
						osr_cnt_reg <= last_sample ? 10'h000 : osr_cnt_reg + 10'h001; // [R3]
						if (last_sample) begin
							chop_reg <= ~chop_reg; // [R2]
							elem_cnt_reg <= elem_cnt_reg + 3'h1;
							if (last_elem) begin
								// both bytes from one register: never mixed
								result_reg <= acc_next; // [R19] [R21] [R22]
								done_reg <= 1'b1; // [R19]
								busy_reg <= 1'b0;
								state_reg <= ACC_IDLE; // [R4]
							end
						end
					end
				end
				default: state_reg <= ACC_IDLE;
			endcase
		end
	end

	// analog control outputs, registered
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			analog_out <= '0;
			chop_invert_out <= 1'b0;
			sample_tick_out <= 1'b0;
			conv_done_out <= 1'b0;
			avs_waitrequest_out <= 1'b1;
		end else begin
			analog_out.input_channel_select <= cfg5_reg[5:1]; // [R17]
			analog_out.ref_pair_select <= cfg5_reg[0]; // [R18]
			analog_out.block_enable <= cfg1_reg[3:0]; // [R8]
			analog_out.modulator_bias_select <= cfg1_reg[7:6]; // [R6]
			analog_out.amplifier_bias_select <= cfg1_reg[5:4]; // [R7]
			analog_out.sample_rate_select <= cfg2_reg[7:6]; // [R9]
			analog_out.stage1_gain_select <= cfg3_reg[7]; // [R10]
			analog_out.stage2_gain_select <= cfg2_reg[5:4]; // [R10]
			// magnitude above 5 steps clamps to plus/minus one
			analog_out.stage2_shift_select <= (cfg2_reg[2:0] > 3'h5) ?
				{cfg2_reg[3], 3'h5} : cfg2_reg[3:0]; // [R12]
			analog_out.stage3_gain_select <= cfg3_reg[6:0]; // [R11]
			analog_out.stage3_shift_select <= cfg4_reg[6:0]; // [R13]
			chop_invert_out <= chop_reg; // [R2]
			sample_tick_out <= tick_reg;
			conv_done_out <= done_reg; // [R19]
			avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_reg);
		end
	end

	// checks
	property p_trig_reads_zero;
		@(posedge clk_in) disable iff (rst_in)
		!avs_waitrequest_out && avs_read_in && avs_address_in == ACC_OFF_CFG0
			|-> !avs_readdata_out[ACC_B_START];
	endproperty
	a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger bit read one"); // [R1]

	property p_test_zero;
		@(posedge clk_in) disable iff (rst_in) cfg0_reg[0] == 1'b0;
	endproperty
	a_test_zero: assert property (p_test_zero) else $error("test bit not zero"); // [R5]

	property p_busy_on_tick;
		@(posedge clk_in) disable iff (rst_in)
		$rose(busy_reg) |-> $past(tick_reg) || $past(def_wr);
	endproperty
	a_busy_on_tick: assert property (p_busy_on_tick) else $error("busy rose off tick"); // [R14]

	property p_done_clears_busy;
		@(posedge clk_in) disable iff (rst_in) done_reg |-> !busy_reg;
	endproperty
	a_done_clears_busy: assert property (p_done_clears_busy) else $error("busy after done"); // [R19]

	property p_def_restarts;
		@(posedge clk_in) disable iff (rst_in)
		def_wr |=> busy_reg && cfg0_reg[4:2] == ACC_DEF_OSR && cfg1_reg[3:0] == ACC_DEF_ENABLE;
	endproperty
	a_def_restarts: assert property (p_def_restarts) else $error("restore failed"); // [R16]

	property p_result_stable;
		@(posedge clk_in) disable iff (rst_in) !done_reg |-> $stable(result_reg);
	endproperty
	a_result_stable: assert property (p_result_stable) else $error("result moved"); // [R22]

	property p_chop_flip;
		@(posedge clk_in) disable iff (rst_in)
		(state_reg == ACC_RUN && tick_reg && last_sample && !last_elem && !def_wr)
			|=> chop_reg != $past(chop_reg);
	endproperty
	a_chop_flip: assert property (p_chop_flip) else $error("no chop flip"); // [R2]

	property p_done_pulse;
		@(posedge clk_in) disable iff (rst_in) conv_done_out |=> !conv_done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse"); // [R19]

	property p_osr_bound;
		@(posedge clk_in) disable iff (rst_in)
		osr_cnt_reg < 10'(pow2({1'b0, cfg0_reg[4:2]} + 4'h3) - 11'h001) || last_sample;
	endproperty
	a_osr_bound: assert property (p_osr_bound) else $error("sample count overrun"); // [R3]

	// waitrequest may only dip for a single cycle per request
	property p_wait_pulse;
		@(posedge clk_in) disable iff (rst_in)
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low twice");

	property p_def_reads_zero;
		@(posedge clk_in) disable iff (rst_in)
		!avs_waitrequest_out && avs_read_in && avs_address_in == ACC_OFF_CFG5
			|-> !avs_readdata_out[ACC_B_DEF];
	endproperty
	a_def_reads_zero: assert property (p_def_reads_zero) else $error("restore read one"); // [R16]

	// a freshly set repeat bit must leave a start pending behind it
	property p_repeat_arms;
		@(posedge clk_in) disable iff (rst_in)
		cfg0_reg[1] && !repeat_conversion_prev_reg |-> pend_reg;
	endproperty
	a_repeat_arms: assert property (p_repeat_arms) else $error("repeat not armed"); // [R4]

	property p_repeat_restarts;
		@(posedge clk_in) disable iff (rst_in)
		state_reg == ACC_IDLE && tick_reg && cfg0_reg[1] && !def_wr |=> busy_reg;
	endproperty
	a_repeat_restarts: assert property (p_repeat_restarts) else $error("repeat stalled"); // [R4]

	// without a request the sequencer stays idle across ticks
	property p_single_waits;
		@(posedge clk_in) disable iff (rst_in)
		state_reg == ACC_IDLE && !pend_reg && !cfg0_reg[1] && !def_wr |=> !busy_reg;
	endproperty
	a_single_waits: assert property (p_single_waits) else $error("unasked start"); // [R20]

	// a trigger taken while busy survives until the sequencer is idle
	property p_pend_held;
		@(posedge clk_in) disable iff (rst_in)
		pend_reg && state_reg == ACC_RUN && !def_wr |=> pend_reg;
	endproperty
	a_pend_held: assert property (p_pend_held) else $error("trigger lost"); // [R1]

	property p_result_from_count;
		@(posedge clk_in) disable iff (rst_in)
		done_reg |-> result_reg == $past(acc_next);
	endproperty
	a_result_from_count: assert property (p_result_from_count) else $error("bad result"); // [R19]

	property p_stage2_limit;
		@(posedge clk_in) disable iff (rst_in)
		analog_out.stage2_shift_select[2:0] <= 3'h5;
	endproperty
	a_stage2_limit: assert property (p_stage2_limit) else $error("shift too big"); // [R12]

	property p_busy_in_run;
		@(posedge clk_in) disable iff (rst_in)
		busy_reg == (state_reg == ACC_RUN);
	endproperty
	a_busy_in_run: assert property (p_busy_in_run) else $error("busy out of step"); // [R14]
endmodule // acc_ctrl
`default_nettype wire

// File: tb/acc_mod_model.sv
// modulator stand-in: one bit per sampling tick, sign follows chop polarity
// assumes the controller undoes the chop sign before counting
`default_nettype none
module acc_mod_model (
	// level from the bench, polarity from the controller
	input wire logic level_in,
	input wire logic chop_invert_in,
	// bit towards the controller
	output logic mod_bit_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// chopped input flips the raw bit, so a steady level gives a fixed count
	assign mod_bit_out = level_in ^ chop_invert_in;
endmodule // acc_mod_model
`default_nettype wire

// File: tb/acc_ctrl_tb.sv
// bench for the acquisition chain controller: avalon register tasks
// assumes the modulator stand-in and a 20 MHz clock
`default_nettype none
module acc_ctrl_tb
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic wait_req;
	logic mod_bit;
	logic level = 1'b1;
	acc_analog_t ana;
	acc_analog_t exp_a;
	logic chop;
	logic tick;
	logic done;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int gap;
	logic [7:0] q;
	logic [7:0] lo;
	logic [7:0] rst_img [6] = '{8'h28, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] cfg_set [2] = '{8'hE0, 8'h8C};
	logic [15:0] res_exp [2] = '{16'hFFC0, 16'h0040};

	// 50 ns period
	always #25 clk_in = ~clk_in;

	acc_ctrl acc_ctrl_i (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_req), .mod_bit_in(mod_bit),
		.analog_out(ana), .chop_invert_out(chop), .sample_tick_out(tick),
		.conv_done_out(done));
	acc_mod_model acc_mod_model_i (.level_in(level), .chop_invert_in(chop),
		.mod_bit_out(mod_bit));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// cut a hang short; the whole run needs about 11000 cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_in);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= {24'h000000, d};
		@(posedge clk_in);
		while (wait_req !== 1'b0) @(posedge clk_in);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// done pulse expected (or not) within a cycle budget
	task automatic wait_done(input int limit, input logic exp);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (done !== 1'b1 && n < limit);
		chk(48'(n < limit), 48'(exp));
	endtask

	task automatic result(input logic [15:0] exp);
		bus(1'b0, ACC_OFF_RES_LO, 8'h00);
		lo = q;
		bus(1'b0, ACC_OFF_RES_HI, 8'h00);
		chk(48'({q, lo}), 48'(exp));
	endtask

	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 5'(ACC_OFF_CFG0 + 4 * i), 8'h00);
			chk(48'(q), 48'(rst_img[i]));
		end
		result(16'h0000);
		bus(1'b1, ACC_OFF_CFG0, 8'h01);
		bus(1'b0, ACC_OFF_CFG0, 8'h00);
		chk(48'(q), 48'h00);
		$display("test reset and test bit done");
		// single shot of 8 samples, second trigger while busy
		bus(1'b1, ACC_OFF_CFG0, 8'h80);
		repeat (44) @(posedge clk_in);
		bus(1'b0, ACC_OFF_CFG5, 8'h00);
		chk(48'(q[7]), 48'h1);
		bus(1'b1, ACC_OFF_CFG0, 8'h80);
		wait_done(400, 1'b1);
		result(16'h0008);
		wait_done(400, 1'b1);
		wait_done(600, 1'b0);
		bus(1'b0, ACC_OFF_CFG0, 8'h00);
		chk(48'(q), 48'h00);
		bus(1'b0, ACC_OFF_CFG5, 8'h00);
		chk(48'(q[7]), 48'h0);
		$display("test single shot done");
		// eight chopped conversions at level low, then ratio 64 at level high
		for (int i = 0; i < 2; i++) begin
			level <= i[0];
			bus(1'b1, ACC_OFF_CFG0, cfg_set[i]);
			wait_done(2800, 1'b1);
			result(res_exp[i]);
		end
		$display("test counts done");
		bus(1'b1, ACC_OFF_CFG0, 8'h02);
		wait_done(400, 1'b1);
		wait_done(400, 1'b1);
		bus(1'b1, ACC_OFF_CFG0, 8'h00);
		repeat (400) @(posedge clk_in);
		wait_done(600, 1'b0);
		$display("test repeat done");
		// analog image of every field, stage two shift limited to five steps
		bus(1'b1, ACC_OFF_CFG1, 8'h5A);
		bus(1'b1, ACC_OFF_CFG2, 8'h5F);
		bus(1'b1, ACC_OFF_CFG3, 8'hFF);
		bus(1'b1, ACC_OFF_CFG4, 8'hC5);
		bus(1'b1, ACC_OFF_CFG5, 8'h3F);
		bus(1'b0, ACC_OFF_CFG5, 8'h00);
		chk(48'(q), 48'h3F);
		bus(1'b0, ACC_OFF_CFG4, 8'h00);
		chk(48'(q), 48'h45);
		exp_a = '{input_channel_select: 5'h1F, ref_pair_select: 1'b1, block_enable: 4'hA,
			modulator_bias_select: 2'h1, amplifier_bias_select: 2'h1,
			sample_rate_select: 2'h1, stage1_gain_select: 1'b1, stage2_gain_select: 2'h1,
			stage2_shift_select: 4'hD, stage3_gain_select: 7'h7F,
			stage3_shift_select: 7'h45};
		chk(48'(ana), 48'(exp_a));
		$display("test analog image done");
		// long run abandoned by restore, defaults finish well before it would
		bus(1'b1, ACC_OFF_CFG0, 8'hE0);
		repeat (200) @(posedge clk_in);
		bus(1'b1, ACC_OFF_CFG5, 8'h40);
		wait_done(2700, 1'b1);
		result(16'h0040);
		bus(1'b0, ACC_OFF_CFG0, 8'h00);
		chk(48'(q), 48'h28);
		bus(1'b0, ACC_OFF_CFG1, 8'h00);
		chk(48'(q), 48'hD1);
		bus(1'b0, ACC_OFF_CFG2, 8'h00);
		chk(48'(q), 48'h1F);
		// tick spacing at the restored fastest rate
		do begin
			@(posedge clk_in);
		end while (tick !== 1'b1);
		gap = 0;
		do begin
			@(posedge clk_in);
			gap++;
		end while (tick !== 1'b1 && gap < 100);
		chk(48'(gap), 48'(4 * ACC_RC_DIV));
		$display("test restore done");
		tally_and_finish();
	end
endmodule // acc_ctrl_tb
`default_nettype wire
